// ---- dv/dmc_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// *****
// controller side of the command pins
// *****
module dmc_ctl_model (
  // clock
  input  wire logic        clk_i,
  // pins, {cke, cs_n, ras_n, cas_n, we_n}
  output logic      [4:0]  pins_o,
  output logic      [1:0]  ba_o,
  output logic      [12:0] addr_o,
  output logic             dm_o
);
  initial {pins_o, ba_o, addr_o, dm_o} = {5'h17, 2'h0, 13'h0000, 1'b0};
  task automatic issue(input logic [4:0] c, input logic [1:0] b, input logic [12:0] a, input logic m);
    @(posedge clk_i);
    {pins_o, ba_o, addr_o, dm_o} <= {c, b, a, m};
    @(posedge clk_i);
    // released lines show garbage, not the old value
    {pins_o, ba_o, addr_o, dm_o} <= {5'h17, ~b, ~a, ~m};
  endtask : issue
endmodule : dmc_ctl_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // *****
  // bench signals
  // *****
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0, wb_we = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0, wb_dat_o, rd;
  logic [4:0]  pin;
  logic [1:0]  ba;
  logic [12:0] adr;
  logic        dm, col_valid_o, col_write_o, col_last_o, wr_keep_o, rd_first_o, rd_half_o;
  logic        dll_reset_o, dll_enabled_o, drive_reduced_o, self_refresh_o, refresh_o;
  logic [10:0] col_addr_o, o;
  logic [3:0]  banks_open_o;
  int          num_errors = 0, check_count = 0, ticks = 0, bl;
  // rows: {length code, interleave, start column}
  logic [14:0] rows [5] = '{15'h300D, 15'h380D, 15'h2006, 15'h2801, 15'h1003};
  // rows: {pins, bank, address, {banks, loop reset, loop on, drive, self ref, refresh}}
  logic [28:0] hand [11] = '{{5'h13, 2'h2, 13'h0000, 9'h088}, {5'h13, 2'h1, 13'h0000, 9'h0C8},
    {5'h12, 2'h1, 13'h0000, 9'h088}, {5'h12, 2'h1, 13'h0400, 9'h008}, {5'h10, 2'h1, 13'h0003, 9'h004},
    {5'h10, 2'h1, 13'h0000, 9'h008}, {5'h10, 2'h0, 13'h0121, 9'h018}, {5'h10, 2'h0, 13'h0021, 9'h008},
    {5'h11, 2'h0, 13'h0000, 9'h009}, {5'h10, 2'h1, 13'h0001, 9'h000}, {5'h01, 2'h0, 13'h0000, 9'h002}};
  dmc_ctl_model ctl_u (.clk_i, .pins_o(pin), .ba_o(ba), .addr_o(adr), .dm_o(dm));
  dmc_cmd_mode dut_u (.clk_i, .rst_i, .ce_i(1'b1), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(4'hF),
    .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_dat_o, .wb_ack_o, .cke_i(pin[4]),
    .cs_n_i(pin[3]), .ras_n_i(pin[2]), .cas_n_i(pin[1]), .we_n_i(pin[0]), .ba_i(ba), .addr_i(adr),
    .dm_i(dm), .col_addr_o, .col_valid_o, .col_write_o, .col_last_o, .wr_keep_o, .rd_first_o, .rd_half_o,
    .dll_reset_o, .dll_enabled_o, .drive_reduced_o, .self_refresh_o, .refresh_o, .banks_open_o);
  initial forever #12.5 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // sample just after an edge has landed
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc
  // classic single cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_we, wb_adr, wb_wdat} <= {1'b1, w, a, d};
    // ack ends this wait; the hang guard catches a missing ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
  endtask : wb
  task automatic summarize;
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // hang guard, far above the few hundred cycles used
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == 2000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(1);
    chk("rst", 13'h0001, {banks_open_o, self_refresh_o, dll_enabled_o});
    foreach (rows[r]) begin
      bl = 1 << rows[r][14:12];
      ctl_u.issue(5'h10, 2'h0, {6'h00, dmc_pkg::DMC_LAT_2, rows[r][11], rows[r][14:12]}, 1'b0);
      ctl_u.issue(5'h14, 2'h0, {2'h0, rows[r][10:0]}, r[0]);
      cyc(1);
      chk("keep", {12'h0, ~r[0]}, {12'h0, wr_keep_o});
      for (int i = 0; i < bl; i++) begin
        cyc(1);
        o = rows[r][11] ? (rows[r][10:0] ^ 11'(i)) : (rows[r][10:0] + 11'(i));
        chk("beat", {1'b1, 1'(i == bl - 1), (rows[r][10:0] & ~11'(bl - 1)) | (o & 11'(bl - 1))},
          {col_valid_o, col_last_o, col_addr_o});
        chk("wr", 13'h0001, {12'h0, col_write_o});
      end
    end
    cyc(200);
    for (int l = 0; l < 2; l++) begin
      ctl_u.issue(5'h10, 2'h0, {6'h00, l ? dmc_pkg::DMC_LAT_2P5 : dmc_pkg::DMC_LAT_2, 4'h1}, 1'b0);
      ctl_u.issue(5'h15, 2'h0, 13'h0000, 1'b0);
      cyc(2 + l);
      chk("early", 13'h0, {12'h0, rd_first_o});
      cyc(1);
      chk("first", {11'h0, 1'b1, 1'(l)}, {11'h0, rd_first_o, rd_half_o});
      cyc(3);
    end
    ctl_u.issue(5'h10, 2'h0, {6'h00, dmc_pkg::DMC_LAT_2, 4'h3}, 1'b0);
    ctl_u.issue(5'h15, 2'h0, 13'h0000, 1'b0);
    cyc(2);
    ctl_u.issue(5'h16, 2'h0, 13'h0000, 1'b0);
    cyc(1);
    chk("stop", 13'h0, {12'h0, col_valid_o});
    foreach (hand[h]) begin
      ctl_u.issue(hand[h][28:24], hand[h][23:22], hand[h][21:9], 1'b0);
      cyc(1);
      chk("state", {4'h0, hand[h][8:0]}, {4'h0, banks_open_o, dll_reset_o, dll_enabled_o,
        drive_reduced_o, self_refresh_o, refresh_o});
    end
    wb(1'b0, 8'h08, 32'h0);
    chk("mode", 13'h0021, rd[12:0]);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 13'h0, rd[12:0]);
    ctl_u.issue(5'h10, 2'h2, 13'h0000, 1'b0);
    wb(1'b0, 8'h04, 32'h0);
    chk("status", 13'h0120, rd[12:0] & 13'h0130);
    wb(1'b1, 8'h04, 32'h100);
    wb(1'b0, 8'h04, 32'h0);
    chk("cleared", 13'h0020, rd[12:0] & 13'h0130);
    ctl_u.issue(5'h15, 2'h0, 13'h0000, 1'b0);
    wb(1'b0, 8'h04, 32'h0);
    chk("lockwait", 13'h0200, rd[12:0] & 13'h0200);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 13'h0001, rd[12:0]);
    summarize();
  end
endmodule : testbench
`default_nettype wire

// ---- logic/dmc_burst_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmc_burst_seq (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // burst request
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic [10:0] start_col_i,
  input  wire logic [2:0]  len_code_i,
  input  wire logic        interleave_i,
  input  wire logic        write_i,
  // column stream
  output logic      [10:0] col_o,
  output logic             valid_o,
  output logic             write_o,
  output logic             last_o
);

  // ***************************************
  // burst state
  // ***************************************
  logic [7:0] base_q, base_d;  // aligned block bits 10..3
  logic [2:0] beg_q, beg_d;    // start offset in the block
  logic [2:0] cnt_q, cnt_d;    // beats issued
  logic [2:0] msk_q, msk_d;    // burst length minus one
  logic       il_q, il_d;      // interleaved order
  logic       act_q, act_d;    // burst running
  logic       wr_q, wr_d;
  logic [2:0] off;             // offset of the next beat

  // length code to low-bit mask, unknown codes act as length 2
  function automatic logic [2:0] len_mask(input logic [2:0] code);
    unique case (code)
      dmc_pkg::DMC_BL8: len_mask = 3'h7;
      dmc_pkg::DMC_BL4: len_mask = 3'h3;
      default:          len_mask = 3'h1;
    endcase
  endfunction : len_mask

  // next beat and burst bookkeeping
  always_comb begin
    base_d = base_q;
    beg_d  = beg_q;
    cnt_d  = cnt_q;
    msk_d  = msk_q;
    il_d   = il_q;
    act_d  = act_q;
    wr_d   = wr_q;
    off = il_q ? (beg_q ^ cnt_q) : ((beg_q + cnt_q) & msk_q);
    if (start_i) begin
      msk_d  = len_mask(len_code_i);
      base_d = start_col_i[10:3];
      beg_d  = start_col_i[2:0];
      il_d   = interleave_i;
      wr_d   = write_i;
      cnt_d  = 3'h0;
      act_d  = 1'b1;
    end else if (stop_i || (act_q && cnt_q == msk_q)) begin
      act_d = 1'b0;
    end else if (act_q) begin
      cnt_d = cnt_q + 3'h1;
    end
  end

  // register state and the registered stream
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_q  <= 8'h00;
      beg_q   <= 3'h0;
      cnt_q   <= 3'h0;
      msk_q   <= 3'h1;
      il_q    <= 1'b0;
      act_q   <= 1'b0;
      wr_q    <= 1'b0;
      col_o   <= 11'h000;
      valid_o <= 1'b0;
      write_o <= 1'b0;
      last_o  <= 1'b0;
    end else if (ce_i) begin
      base_q  <= base_d;
      beg_q   <= beg_d;
      cnt_q   <= cnt_d;
      msk_q   <= msk_d;
      il_q    <= il_d;
      act_q   <= act_d;
      wr_q    <= wr_d;
      valid_o <= act_q && !stop_i && !start_i;
      write_o <= wr_q;
      last_o  <= act_q && cnt_q == msk_q;
      col_o   <= {base_q, 3'h0} | {8'h00, off} | {8'h00, beg_q & ~msk_q};
    end
  end

  // ***************************************
  // checks
  // ***************************************
  AST_BLOCK_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && valid_o && !last_o && !start_i && !stop_i |=> col_o[10:3] == $past(col_o[10:3]))
    else $error("burst left its block");
  AST_SEQ_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && valid_o && !last_o && !il_q && !start_i && !stop_i
    |=> ((col_o[2:0] - $past(col_o[2:0])) & msk_q) == 3'h1)
    else $error("sequential beat out of order");

endmodule : dmc_burst_seq
`default_nettype wire

// ---- logic/dmc_cmd_mode.sv ----
// Overview of operation
// - burst type bit picks order
// - latency two or two and half
// - first read data at n plus m
// - sequential adds, interleaved xors offset
// - burst wraps inside its aligned block
// - low column bits pick first beat
// - zero upper bits select normal mode
// - bit eight alone resets loop
// - bank bits choose base or extended
// - extended holds loop enable, drive
// - self refresh exit re-enables loop
// - decode chip select and strobes
// - refresh: auto, or self with cke low
// - column from low bits, bit ten precharge
// - precharge one bank or all banks
// - mask low writes, high inhibits
// - base register field layout
// - base kept, loop reset bit clears
// - inputs registered one clock first
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dmc_cmd_mode (
  // clock, reset, freeze
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // command and address pins
  input  wire logic        cke_i,
  input  wire logic        cs_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  ba_i,
  input  wire logic [12:0] addr_i,
  input  wire logic        dm_i,
  // column stream
  output logic      [10:0] col_addr_o,
  output logic             col_valid_o,
  output logic             col_write_o,
  output logic             col_last_o,
  output logic             wr_keep_o,
  // read timing
  output logic             rd_first_o,
  output logic             rd_half_o,
  // mode and bank state
  output logic             dll_reset_o,
  output logic             dll_enabled_o,
  output logic             drive_reduced_o,
  output logic             self_refresh_o,
  output logic             refresh_o,
  output logic      [3:0]  banks_open_o
);

  // ***************************************
  // input register stage
  // ***************************************
  logic        cke_q, cs_n_q, ras_n_q, cas_n_q, we_n_q;  // staged controls
  logic [1:0]  ba_q;                                      // staged bank
  logic [12:0] addr_q;                                    // staged address
  logic        dm_q;                                      // staged mask

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cke_q   <= 1'b0;
      cs_n_q  <= 1'b1;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q  <= 1'b1;
      ba_q    <= 2'h0;
      addr_q  <= 13'h0000;
      dm_q    <= 1'b1;
    end else if (ce_i) begin
      cke_q   <= cke_i;
      cs_n_q  <= cs_n_i;
      ras_n_q <= ras_n_i;
      cas_n_q <= cas_n_i;
      we_n_q  <= we_n_i;
      ba_q    <= ba_i;
      addr_q  <= addr_i;
      dm_q    <= dm_i;
    end
  end

  // strobe decode, all eight low-select codes are defined
  function automatic dmc_pkg::dmc_cmd_t decode(input logic cs_n, input logic [2:0] rcw);
    if (cs_n) begin
      decode = dmc_pkg::DMC_CMD_DESEL;
    end else begin
      unique case (rcw)
        3'h7: decode = dmc_pkg::DMC_CMD_NOP;
        3'h3: decode = dmc_pkg::DMC_CMD_ACT;
        3'h5: decode = dmc_pkg::DMC_CMD_RD;
        3'h4: decode = dmc_pkg::DMC_CMD_WR;
        3'h6: decode = dmc_pkg::DMC_CMD_BST;
        3'h2: decode = dmc_pkg::DMC_CMD_PRE;
        3'h1: decode = dmc_pkg::DMC_CMD_REF;
        3'h0: decode = dmc_pkg::DMC_CMD_MRS;
      endcase
    end
  endfunction : decode

  // ***************************************
  // core state
  // ***************************************
  dmc_pkg::dmc_cmd_t cmd;               // decoded staged command
  logic [12:0] mode_q, mode_d;          // base mode register
  logic [12:0] ext_q, ext_d;            // extended mode register
  logic [3:0]  open_q, open_d;          // open banks
  logic        sref_q, sref_d;          // self refresh
  logic        dllrst_q, dllrst_d;      // loop reset pulse
  logic [7:0]  lock_q, lock_d;          // lock wait countdown
  logic        ill_q, ill_d;            // sticky illegal
  logic        early_q, early_d;        // sticky early read
  logic        aref_q, aref_d;          // auto refresh pulse
  logic [1:0]  rcnt_q, rcnt_d;          // read latency countdown
  logic        half_q, half_d;          // half clock flag
  logic        rfire_q, rfire_d;        // first read data
  logic [10:0] pcol_q, pcol_d;          // pending read column
  logic [1:0]  pba_q, pba_d;            // pending read bank
  logic        pap_q, pap_d;            // pending read auto precharge
  logic [1:0]  cba_q, cba_d;            // running burst bank
  logic        cap_q, cap_d;            // running burst auto precharge
  logic        crd_q, crd_d;            // running burst is a read
  logic        keep_q, keep_d;          // write enable for this beat
  logic        wide_q;                  // control: wide column
  logic        clr_ill, clr_early;      // bus clear strobes
  logic        bs_start, bs_stop, bs_wr;
  logic [10:0] bs_col;
  logic [10:0] cmd_col;

  // column from the staged address, bit 11 joins on the wide part
  assign cmd_col = {wide_q & addr_q[11], addr_q[9:0]};

  // command effects on modes, banks and bursts
  always_comb begin
    cmd      = decode(cs_n_q, {ras_n_q, cas_n_q, we_n_q});
    mode_d   = mode_q;
    ext_d    = ext_q;
    open_d   = open_q;
    sref_d   = sref_q;
    dllrst_d = 1'b0;
    lock_d   = (lock_q != 8'h00 && cke_q) ? lock_q - 8'h01 : lock_q;
    ill_d    = ill_q & ~clr_ill;
    early_d  = early_q & ~clr_early;
    aref_d   = 1'b0;
    rcnt_d   = (rcnt_q != 2'h0) ? rcnt_q - 2'h1 : rcnt_q;
    half_d   = half_q;
    rfire_d  = 1'b0;
    pcol_d   = pcol_q;
    pba_d    = pba_q;
    pap_d    = pap_q;
    cba_d    = cba_q;
    cap_d    = cap_q;
    crd_d    = crd_q;
    keep_d   = ~dm_q;
    bs_start = 1'b0;
    bs_stop  = 1'b0;
    bs_wr    = 1'b0;
    bs_col   = cmd_col;
    mode_d[dmc_pkg::DMC_MR_DLLRST] = 1'b0;
    // auto precharge closes the bank at the last beat
    if (col_last_o && cap_q) begin
      open_d[cba_q] = 1'b0;
    end
    // pending read reaches its data edge
    if (rcnt_q == 2'h1) begin
      rfire_d  = 1'b1;
      bs_start = 1'b1;
      bs_col   = pcol_q;
      cba_d    = pba_q;
      cap_d    = pap_q;
      crd_d    = 1'b1;
    end
    if (sref_q) begin
      if (cke_q) begin
        sref_d = 1'b0;
        ext_d[dmc_pkg::DMC_EMR_DLL_DIS] = 1'b0;
        lock_d = dmc_pkg::DMC_DLL_LOCK_CYC;
      end
    end else if (!cke_q) begin
      if (cmd == dmc_pkg::DMC_CMD_REF) begin
        sref_d = 1'b1;
      end
    end else begin
      unique case (cmd)
        dmc_pkg::DMC_CMD_ACT: open_d[ba_q] = 1'b1;
        dmc_pkg::DMC_CMD_RD: begin
          if (lock_q != 8'h00 || ext_q[dmc_pkg::DMC_EMR_DLL_DIS]) begin
            early_d = 1'b1;
          end
          rcnt_d = (mode_q[6:4] == dmc_pkg::DMC_LAT_2P5) ? dmc_pkg::DMC_RD_CNT_2P5 : dmc_pkg::DMC_RD_CNT_2;
          half_d = mode_q[6:4] == dmc_pkg::DMC_LAT_2P5;
          pcol_d = cmd_col;
          pba_d  = ba_q;
          pap_d  = addr_q[dmc_pkg::DMC_AP_BIT];
        end
        dmc_pkg::DMC_CMD_WR: begin
          bs_start = 1'b1;
          bs_wr    = 1'b1;
          cba_d    = ba_q;
          cap_d    = addr_q[dmc_pkg::DMC_AP_BIT];
          crd_d    = 1'b0;
        end
        dmc_pkg::DMC_CMD_BST: begin
          if (col_valid_o && crd_q && !cap_q) begin
            bs_stop = 1'b1;
          end
        end
        dmc_pkg::DMC_CMD_PRE: begin
          if (addr_q[dmc_pkg::DMC_AP_BIT]) begin
            open_d = 4'h0;
          end else begin
            open_d[ba_q] = 1'b0;
          end
        end
        dmc_pkg::DMC_CMD_REF: aref_d = 1'b1;
        dmc_pkg::DMC_CMD_MRS: begin
          if (ba_q == dmc_pkg::DMC_BA_MODE) begin
            if (mode_lat_bad(addr_q[6:4]) || addr_q[2:0] == 3'h0 || addr_q[2:0] > dmc_pkg::DMC_BL8) begin
              ill_d = 1'b1;
            end
            if (addr_q[12:7] == dmc_pkg::DMC_OPM_NORMAL) begin
              mode_d = {6'h00, addr_q[6:0]};
            end else if (addr_q[12:7] == dmc_pkg::DMC_OPM_DLLRST) begin
              mode_d   = {6'h00, addr_q[6:0]};
              dllrst_d = 1'b1;
              lock_d   = dmc_pkg::DMC_DLL_LOCK_CYC;
            end else begin
              ill_d = 1'b1;
            end
          end else if (ba_q == dmc_pkg::DMC_BA_EXT) begin
            ext_d = addr_q;
            if (ext_q[dmc_pkg::DMC_EMR_DLL_DIS] && !addr_q[dmc_pkg::DMC_EMR_DLL_DIS]) begin
              lock_d = dmc_pkg::DMC_DLL_LOCK_CYC;
            end
          end else begin
            ill_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // latency codes other than 2 and 2.5 are reserved
  function automatic logic mode_lat_bad(input logic [2:0] lat);
    mode_lat_bad = lat != dmc_pkg::DMC_LAT_2 && lat != dmc_pkg::DMC_LAT_2P5;
  endfunction : mode_lat_bad

  // register core state; ce low freezes everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q  <= dmc_pkg::DMC_MODE_RST;
      ext_q   <= dmc_pkg::DMC_EXT_RST;
      open_q  <= 4'h0;
      sref_q  <= 1'b0;
      dllrst_q <= 1'b0;
      lock_q  <= dmc_pkg::DMC_DLL_LOCK_CYC;
      ill_q   <= 1'b0;
      early_q <= 1'b0;
      aref_q  <= 1'b0;
      rcnt_q  <= 2'h0;
      half_q  <= 1'b0;
      rfire_q <= 1'b0;
      pcol_q  <= 11'h000;
      pba_q   <= 2'h0;
      pap_q   <= 1'b0;
      cba_q   <= 2'h0;
      cap_q   <= 1'b0;
      crd_q   <= 1'b0;
      keep_q  <= 1'b0;
    end else if (ce_i) begin
      mode_q  <= mode_d;
      ext_q   <= ext_d;
      open_q  <= open_d;
      sref_q  <= sref_d;
      dllrst_q <= dllrst_d;
      lock_q  <= lock_d;
      ill_q   <= ill_d;
      early_q <= early_d;
      aref_q  <= aref_d;
      rcnt_q  <= rcnt_d;
      half_q  <= half_d;
      rfire_q <= rfire_d;
      pcol_q  <= pcol_d;
      pba_q   <= pba_d;
      pap_q   <= pap_d;
      cba_q   <= cba_d;
      cap_q   <= cap_d;
      crd_q   <= crd_d;
      keep_q  <= keep_d;
    end
  end

  dmc_burst_seq u_seq (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .start_i      (bs_start),
    .stop_i       (bs_stop),
    .start_col_i  (bs_col),
    .len_code_i   (mode_q[2:0]),
    .interleave_i (mode_q[dmc_pkg::DMC_MR_TYPE]),
    .write_i      (bs_wr),
    .col_o        (col_addr_o),
    .valid_o      (col_valid_o),
    .write_o      (col_write_o),
    .last_o       (col_last_o)
  );

  assign wr_keep_o       = keep_q;
  assign rd_first_o      = rfire_q;
  assign rd_half_o       = half_q;
  assign dll_reset_o     = dllrst_q;
  assign dll_enabled_o   = ~ext_q[dmc_pkg::DMC_EMR_DLL_DIS];
  assign drive_reduced_o = ext_q[dmc_pkg::DMC_EMR_DRIVE];
  assign self_refresh_o  = sref_q;
  assign refresh_o       = aref_q;
  assign banks_open_o    = open_q;

  // ***************************************
  // wishbone register slave
  // ***************************************
  logic        ack_d, wide_d;
  logic [31:0] rdat_d;
  logic        req;

  // one-cycle answer, ack drops the cycle after
  always_comb begin
    req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    ack_d     = req;
    wide_d    = wide_q;
    clr_ill   = 1'b0;
    clr_early = 1'b0;
    rdat_d    = 32'h0000_0000;
    unique case (wb_adr_i)
      dmc_pkg::DMC_OFF_CTRL:   rdat_d[dmc_pkg::DMC_CTRL_WIDE] = wide_q;
      dmc_pkg::DMC_OFF_STATUS: begin
        rdat_d[3:0]                     = open_q;
        rdat_d[dmc_pkg::DMC_ST_SREF]    = sref_q;
        rdat_d[dmc_pkg::DMC_ST_DLL_EN]  = ~ext_q[dmc_pkg::DMC_EMR_DLL_DIS];
        rdat_d[dmc_pkg::DMC_ST_DLL_RDY] = lock_q == 8'h00;
        rdat_d[dmc_pkg::DMC_ST_ILLEGAL] = ill_q;
        rdat_d[dmc_pkg::DMC_ST_EARLY]   = early_q;
      end
      dmc_pkg::DMC_OFF_MODE:   rdat_d[12:0] = mode_q;
      dmc_pkg::DMC_OFF_EXT:    rdat_d[12:0] = ext_q;
      default:                 rdat_d = 32'h0000_0000;
    endcase
    if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == dmc_pkg::DMC_OFF_CTRL) begin
      wide_d = wb_dat_i[dmc_pkg::DMC_CTRL_WIDE];
    end
    // sticky clears lose to a same-cycle set
    if (req && wb_we_i && wb_sel_i[1] && wb_adr_i == dmc_pkg::DMC_OFF_STATUS) begin
      clr_ill   = wb_dat_i[dmc_pkg::DMC_ST_ILLEGAL];
      clr_early = wb_dat_i[dmc_pkg::DMC_ST_EARLY];
    end
  end

  // register bus state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      wide_q   <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
      wide_q   <= wide_d;
    end
  end

  // ***************************************
  // checks
  // ***************************************
  AST_DLL_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cke_q && !sref_q && cmd == dmc_pkg::DMC_CMD_MRS && ba_q == 2'h0 && addr_q[12:7] == 6'h02
    |=> dll_reset_o && mode_q[6:0] == $past(addr_q[6:0]))
    else $error("loop reset load not applied");
  AST_A8_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && dll_reset_o && cmd != dmc_pkg::DMC_CMD_MRS |=> !dll_reset_o && !mode_q[8])
    else $error("loop reset bit stuck");
  AST_PRE_ALL: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cke_q && !sref_q && cmd == dmc_pkg::DMC_CMD_PRE && addr_q[10] |=> banks_open_o == 4'h0)
    else $error("precharge all left a bank open");
  AST_ACT_OPEN: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cke_q && !sref_q && cmd == dmc_pkg::DMC_CMD_ACT |=> banks_open_o[$past(ba_q)])
    else $error("activate did not open bank");
  AST_RD_LAT2: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cke_q && !sref_q && cmd == dmc_pkg::DMC_CMD_RD && mode_q[6:4] == 3'h2 ##1 ce_i [*2]
    |=> rd_first_o && !rd_half_o)
    else $error("latency two read misplaced");
  AST_SREF_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !cke_q && !sref_q && cmd == dmc_pkg::DMC_CMD_REF |=> self_refresh_o)
    else $error("self refresh not entered");

endmodule : dmc_cmd_mode
`default_nettype wire

// ---- logic/dmc_pkg.sv ----
`default_nettype none
package dmc_pkg;

  // ***************************************
  // command codes seen on the pins
  // ***************************************
  typedef enum logic [3:0] {
    DMC_CMD_DESEL,
    DMC_CMD_NOP,
    DMC_CMD_ACT,
    DMC_CMD_RD,
    DMC_CMD_WR,
    DMC_CMD_BST,
    DMC_CMD_PRE,
    DMC_CMD_REF,
    DMC_CMD_MRS
  } dmc_cmd_t;

  // ***************************************
  // register offsets (byte addresses)
  // ***************************************
  localparam logic [7:0]  DMC_OFF_CTRL   = 8'h00;  // control
  localparam logic [7:0]  DMC_OFF_STATUS = 8'h04;  // live state and sticky flags
  localparam logic [7:0]  DMC_OFF_MODE   = 8'h08;  // base mode image
  localparam logic [7:0]  DMC_OFF_EXT    = 8'h0C;  // extended mode image

  // ***************************************
  // field positions
  // ***************************************
  localparam int DMC_CTRL_WIDE   = 0;   // use address bit 11 as column bit 10
  localparam int DMC_ST_SREF     = 4;   // self refresh active
  localparam int DMC_ST_DLL_EN   = 5;   // loop enabled
  localparam int DMC_ST_DLL_RDY  = 6;   // lock wait over
  localparam int DMC_ST_ILLEGAL  = 8;   // sticky, write one to clear
  localparam int DMC_ST_EARLY    = 9;   // sticky read before lock, write one to clear
  localparam int DMC_MR_TYPE     = 3;   // burst type bit
  localparam int DMC_MR_DLLRST   = 8;   // self-clearing loop reset bit
  localparam int DMC_EMR_DLL_DIS = 0;   // high disables the loop
  localparam int DMC_EMR_DRIVE   = 1;   // reduced drive strength
  localparam int DMC_AP_BIT      = 10;  // auto precharge / precharge-all bit

  // ***************************************
  // codes and reset values
  // ***************************************
  localparam logic [2:0]  DMC_BL2        = 3'h1;
  localparam logic [2:0]  DMC_BL4        = 3'h2;
  localparam logic [2:0]  DMC_BL8        = 3'h3;
  localparam logic [2:0]  DMC_LAT_2      = 3'h2;   // two clocks
  localparam logic [2:0]  DMC_LAT_2P5    = 3'h6;   // two and a half clocks
  localparam logic [5:0]  DMC_OPM_NORMAL = 6'h00;
  localparam logic [5:0]  DMC_OPM_DLLRST = 6'h02;
  localparam logic [12:0] DMC_MODE_RST   = 13'h0000;
  localparam logic [12:0] DMC_EXT_RST    = 13'h0000;
  localparam logic [1:0]  DMC_BA_MODE    = 2'h0;
  localparam logic [1:0]  DMC_BA_EXT     = 2'h1;

  // ***************************************
  // timing counts
  // ***************************************
  localparam logic [7:0]  DMC_DLL_LOCK_CYC = 8'hC8;  // 200 clocks with cke high
  localparam logic [1:0]  DMC_RD_CNT_2     = 2'h2;   // whole clocks for latency 2
  localparam logic [1:0]  DMC_RD_CNT_2P5   = 2'h3;   // 2.5 rounded up, half flag set

endpackage : dmc_pkg
`default_nettype wire
